// File: design/pfcdc_ctrl.sv
/*
  Boost PFC controller: voltage PI with power limits and anti-windup,
  voltage feedforward, current PI with anti-windup, duty feedforward
  with soft start. Assumes one sample strobe per control interval from
  logic on core_clk_i, with all measurements valid on that cycle.
*/
// Behaviour
// [R1] each interval, voltage error is commanded minus measured bus voltage into PI
// [R2] voltage PI clamps integral and output magnitude between bounds
// [R3] limiter after voltage PI keeps power demand at or above zero
// [R4] power demand times voltage feedforward coefficient gives current command
// [R5] voltage integral gain is multiplied by the control interval
// [R6] power limit is Vrms times slope, loaded into both voltage clamps
// [R7] at or above 200 Vrms the limit holds at the 1 kW ceiling
// [R8] between 100 and 200 Vrms the limit rises linearly
// [R9] below 100 Vrms the limit holds at the 500 W floor
// [R10] margin coefficient from 1.0 to 1.4 scales the power limits
// [R11] slope is power span over voltage span; limits are thresholds times slope
// [R12] on voltage saturation integrator becomes limit minus proportional term
// [R13] feedforward coefficient is instantaneous voltage over Vrms squared
// [R14] current PI drives reactor current to follow the command
// [R15] on current saturation integrator becomes duty limit minus proportional term
// [R16] duty feedforward is one minus input over output voltage, added to duty
// [R17] soft start ramps feedforward weight from zero to one
// [R18] final duty combines current PI result with feedforward compensation
// [R19] surroundings strobe once per interval with fresh samples
// [R20] reset clears integrators and ramp; duty zero until first strobe
`timescale 1ns/1ps
`default_nettype none
module pfcdc_ctrl
  import pfcdc_pkg::*;
#(
  parameter int TS_NS_P = TS_NS            // control interval in ns
) (
  input  wire logic                core_clk_i,    // control clock
  input  wire logic                rst_i,         // async reset, high
  input  wire logic                sample_stb_i,  // one pulse per interval
  input  wire logic signed [W-1:0] vac_i,         // instantaneous AC volts
  input  wire logic signed [W-1:0] vrms_i,        // input RMS volts
  input  wire logic signed [W-1:0] ipfc_i,        // reactor current
  input  wire logic signed [W-1:0] vdc_i,         // bus volts
  input  wire logic signed [W-1:0] vcmd_i,        // bus volts command
  input  wire logic signed [W-1:0] kp_v_i,        // voltage P gain
  input  wire logic signed [W-1:0] ki_v_i,        // voltage I gain, per s
  input  wire logic signed [W-1:0] kp_i_i,        // current P gain
  input  wire logic signed [W-1:0] ki_i_i,        // current I gain
  input  wire logic signed [W-1:0] margin_i,      // power margin
  input  wire logic signed [W-1:0] duty_lim_i,    // duty output limit
  input  wire logic signed [W-1:0] ss_step_i,     // ramp step per interval
  output logic signed [W-1:0]      duty_o,        // gate duty cycle
  output logic signed [W-1:0]      iref_o,        // current command
  output logic signed [W-1:0]      pdem_o,        // power demand
  output logic                     busy_o,        // computing
  output logic                     done_o         // duty updated pulse
);
  // ---------------------------------------------------------------
  // elaboration checks and derived constants
  // ---------------------------------------------------------------
  // Ts carries 24 fraction bits; a very short interval would round to zero
  localparam longint TS_Q_L = (longint'(TS_NS_P) <<< TS_FRAC) / 1_000_000_000;
  localparam logic signed [W-1:0] TS_Q = W'(TS_Q_L);
  if (TS_NS_P <= 0 || TS_Q_L == 0 || TS_Q_L > 64'sh7FFF_FFFF) begin : g_bad_ts
    $error("control interval out of range");
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic signed [W-1:0] sat(input logic signed [63:0] x);
    if (x > 64'(MAX_Q)) sat = MAX_Q;
    else if (x < 64'(MIN_Q)) sat = MIN_Q;
    else sat = x[W-1:0];
  endfunction
  function automatic logic signed [W-1:0] mulq(input logic signed [W-1:0] a,
                                                input logic signed [W-1:0] b);
    mulq = sat((64'(a) * 64'(b)) >>> FRAC);
  endfunction
  function automatic logic signed [W-1:0] clip(input logic signed [W-1:0] x,
                                                input logic signed [W-1:0] lo,
                                                input logic signed [W-1:0] hi);
    if (x > hi) clip = hi;
    else if (x < lo) clip = lo;
    else clip = x;
  endfunction
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    pfcdc_state_t       st;
    logic               started;
    logic               done;
    logic signed [W-1:0] vac;
    logic signed [W-1:0] vrms;
    logic signed [W-1:0] ipfc;
    logic signed [W-1:0] vdc;
    logic signed [W-1:0] lim;
    logic signed [W-1:0] p_v;
    logic signed [W-1:0] int_v;
    logic signed [W-1:0] pdem;
    logic signed [W-1:0] iref;
    logic signed [W-1:0] int_i;
    logic signed [W-1:0] ipo;
    logic signed [W-1:0] ss;
    logic signed [W-1:0] duty;
    logic [DW-1:0]       quo;
    logic [W:0]          rem;
    logic [W-1:0]        den;
    logic                neg;
    logic [7:0]          cnt;
  } pfcdc_regs_t;

  pfcdc_regs_t q, d;

  logic signed [W-1:0] vr_c, err_c, pr_c, ii_c, sum_c, dlim_c, dff_c, mg_c;
  logic signed [63:0]  num_c;
  logic [W:0]          tr_c;
  logic [DW-1:0]       qs_c;

  // ---------------------------------------------------------------
  // sequencer and arithmetic
  // ---------------------------------------------------------------
  always_comb begin
    d      = q;
    d.done = 1'b0;
    vr_c   = ZERO_Q;
    err_c  = ZERO_Q;
    pr_c   = ZERO_Q;
    ii_c   = ZERO_Q;
    sum_c  = ZERO_Q;
    dff_c  = ZERO_Q;
    num_c  = 64'sh0;
    tr_c   = '0;
    qs_c   = (q.quo > DW'(MAX_Q)) ? DW'(MAX_Q) : q.quo;
    dlim_c = clip(duty_lim_i, ZERO_Q, ONE_Q);
    mg_c   = clip(margin_i, MARGIN_MIN_Q, MARGIN_MAX_Q);
    unique case (q.st)
      ST_IDLE: begin
        if (sample_stb_i) begin  // R19
          // latch every sample now: the plant may move them on the next cycle
          d.vac  = vac_i;
          d.vrms = vrms_i;
          d.ipfc = ipfc_i;
          d.vdc  = vdc_i;
          d.st   = ST_VPI;
        end
      end
      ST_VPI: begin
        vr_c  = clip(q.vrms, V_LO_Q, V_HI_Q);                 // R7 R8 R9
        d.lim = mulq(mulq(vr_c, SLOPE_Q), mg_c);              // R6 R10 R11
        err_c = vcmd_i - q.vdc;                               // R1
        pr_c  = mulq(kp_v_i, err_c);
        ii_c  = q.int_v + mulq(sat((64'(ki_v_i) * 64'(TS_Q)) >>> TS_FRAC),
                               err_c);                        // R5
        ii_c  = clip(ii_c, -d.lim, d.lim);                    // R2
        sum_c = sat(64'(pr_c) + 64'(ii_c));
        if (sum_c > d.lim) begin
          sum_c = d.lim;
          ii_c  = sat(64'(d.lim) - 64'(pr_c));                // R12
        end else if (sum_c < -d.lim) begin
          sum_c = -d.lim;
          ii_c  = sat(-64'(d.lim) - 64'(pr_c));               // R12
        end
        d.p_v   = pr_c;
        d.int_v = ii_c;
        d.pdem  = (sum_c < ZERO_Q) ? ZERO_Q : sum_c;          // R3
        // pdem * vac / vrms^2, kept as magnitude plus sign
        num_c   = 64'(d.pdem) * 64'(q.vac);                   // R4 R13
        d.neg   = num_c[63];
        d.quo   = num_c[63] ? DW'(-num_c) : DW'(num_c);
        d.den   = W'((64'(q.vrms) * 64'(q.vrms)) >>> FRAC);
        d.rem   = '0;
        d.cnt   = DIV_STEPS;
        if (d.den == '0) begin
          d.quo = '0;
          d.cnt = 8'h00;
        end
        d.st = ST_VDIV;
      end
      ST_VDIV, ST_DDIV: begin
        if (q.cnt != 8'h00) begin
          // restoring division, one quotient bit per cycle
          tr_c = {q.rem[W-1:0], q.quo[DW-1]};
          d.quo = {q.quo[DW-2:0], 1'b0};
          if (tr_c >= {1'b0, q.den}) begin
            d.rem    = tr_c - {1'b0, q.den};
            d.quo[0] = 1'b1;
          end else begin
            d.rem = tr_c;
          end
          d.cnt = q.cnt - 8'h01;
        end else begin
          d.st = (q.st == ST_VDIV) ? ST_IPI : ST_OUT;
        end
      end
      ST_IPI: begin
        // the sign was split off before the divide; put it back on the command
        d.iref = q.neg ? -W'(qs_c) : W'(qs_c);               // R4
        err_c  = d.iref - q.ipfc;                             // R14
        pr_c   = mulq(kp_i_i, err_c);
        ii_c   = clip(q.int_i + mulq(ki_i_i, err_c), -dlim_c, dlim_c);
        sum_c  = sat(64'(pr_c) + 64'(ii_c));
        if (sum_c > dlim_c) begin
          sum_c = dlim_c;
          ii_c  = sat(64'(dlim_c) - 64'(pr_c));               // R15
        end else if (sum_c < -dlim_c) begin
          sum_c = -dlim_c;
          ii_c  = sat(-64'(dlim_c) - 64'(pr_c));              // R15
        end
        d.int_i = ii_c;
        d.ipo   = sum_c;
        // rectified input over bus voltage for the feedforward
        num_c = 64'((q.vac < ZERO_Q) ? -q.vac : q.vac) <<< FRAC;
        d.quo = DW'(num_c);
        d.den = q.vdc[W-1:0];
        d.rem = '0;
        d.cnt = DIV_STEPS;
        if (q.vdc <= ZERO_Q) begin
          d.quo = DW'(ONE_Q);  // no bus reading: feedforward drops to zero
          d.cnt = 8'h00;
        end
        d.st = ST_DDIV;
      end
      ST_OUT: begin
        // weight is used before it steps, so the first interval has no feedforward
        dff_c  = clip(sat(64'(ONE_Q) - 64'(qs_c)), ZERO_Q, ONE_Q); // R16
        sum_c  = sat(64'(q.ipo) + 64'(mulq(q.ss, dff_c)));         // R16
        d.duty = clip(sum_c, ZERO_Q, dlim_c);                      // R18
        d.ss   = clip(sat(64'(q.ss) + 64'(ss_step_i)), ZERO_Q, ONE_Q); // R17
        d.started = 1'b1;
        d.done = 1'b1;
        d.st   = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;  // R20
    end else begin
      q <= d;
    end
  end

  assign duty_o = q.duty;
  assign iref_o = q.iref;
  assign pdem_o = q.pdem;
  // busy is combinational so a strobe on the done cycle is still taken
  assign busy_o = (q.st != ST_IDLE);
  assign done_o = q.done;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // a pinned output rewrites the integrator to limit minus proportional
  // term, which may lie outside the clamp, so the clamp is judged unpinned
  a_vint_bound: assert property (q.st == ST_VDIV && q.pdem != q.lim &&    // R2
    q.pdem != ZERO_Q |-> q.int_v <= q.lim && q.int_v >= -q.lim)
    else $error("voltage integral out of bounds");
  a_pdem_nonneg: assert property (q.pdem >= ZERO_Q)     // R3
    else $error("power demand negative");
  a_lim_ceiling: assert property (q.st == ST_VDIV && q.vrms >= V_HI_Q |-> // R7
    q.lim == mulq(P_MAX_Q, clip(margin_i, MARGIN_MIN_Q, MARGIN_MAX_Q)))
    else $error("power limit not at ceiling");
  a_lim_floor: assert property (q.st == ST_VDIV && q.vrms < V_LO_Q |->   // R9
    q.lim == mulq(P_MIN_Q, clip(margin_i, MARGIN_MIN_Q, MARGIN_MAX_Q)))
    else $error("power limit not at floor");
  a_vaw_sat: assert property (q.st == ST_VDIV && q.pdem == q.lim |->     // R12
    64'(q.int_v) + 64'(q.p_v) == 64'(q.lim)) else $error("voltage anti-windup wrong");
  a_duty_range: assert property (q.duty >= ZERO_Q && q.duty <= ONE_Q)    // R18
    else $error("duty out of range");
  a_ss_ramp: assert property (q.st == ST_OUT |=>                         // R17
    q.ss >= $past(q.ss) && q.ss <= ONE_Q) else $error("soft start not monotonic");
  a_reset_duty: assert property (!q.started |-> q.duty == ZERO_Q)        // R20
    else $error("duty nonzero before first strobe");
  a_strobe_done: assert property (q.st == ST_IDLE && sample_stb_i |->    // R1
    ##[1:110] done_o) else $error("interval not completed in time");

  a_vout_bound: assert property (q.st == ST_VDIV |-> q.pdem <= q.lim)    // R2
    else $error("power demand above limit");
  a_iout_bound: assert property (q.st == ST_DDIV |->                      // R15
    q.ipo <= clip(duty_lim_i, ZERO_Q, ONE_Q) && q.ipo >= -clip(duty_lim_i, ZERO_Q, ONE_Q))
    else $error("current loop output beyond duty limit");
  a_iref_zero: assert property (q.st == ST_IPI && q.pdem == ZERO_Q |=>    // R4
    q.iref == ZERO_Q) else $error("current command without power demand");
  a_ss_bound: assert property (q.ss >= ZERO_Q && q.ss <= ONE_Q)          // R17
    else $error("soft start weight out of range");
  a_done_pulse: assert property (done_o |=> !done_o)                     // R18
    else $error("done longer than one cycle");

  // ---------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------
  c_interval: cover property (q.st == ST_IDLE && sample_stb_i ##[1:110] done_o);
  c_pwr_sat: cover property (q.st == ST_VDIV && q.pdem == q.lim && q.lim != ZERO_Q);
  c_ss_full: cover property (q.ss == ONE_Q);
  c_duty_lim: cover property (done_o && q.duty == clip(duty_lim_i, ZERO_Q, ONE_Q));
  c_iref_neg: cover property (done_o && q.iref < ZERO_Q);
endmodule
`default_nettype wire

// File: design/pfcdc_pkg.sv
/*
  Constants and types for the boost PFC digital controller.
  Assumes all quantities are signed fixed point with FRAC fraction bits, except the period, which has TS_FRAC.
*/
`default_nettype none
package pfcdc_pkg;
  // ---------------------------------------------------------------
  // number format
  // ---------------------------------------------------------------
  localparam int W    = 32;
  localparam int FRAC = 12;
  localparam int DW   = 48;                // divider dividend width
  localparam int TS_FRAC = 24;             // fraction bits of the period
  localparam logic signed [W-1:0] ONE_Q  = 32'sh0000_1000;
  localparam logic signed [W-1:0] ZERO_Q = 32'sh0000_0000;
  localparam logic signed [W-1:0] MAX_Q  = 32'sh7FFF_FFFF;
  localparam logic signed [W-1:0] MIN_Q  = -32'sh7FFF_FFFF;
  // ---------------------------------------------------------------
  // power limitation figures
  // ---------------------------------------------------------------
  localparam int V_LO_V  = 100;            // Vrms
  localparam int V_HI_V  = 200;            // Vrms
  localparam int P_MIN_W = 500;            // W
  localparam int P_MAX_W = 1000;           // W
  localparam logic signed [W-1:0] V_LO_Q = W'(V_LO_V <<< FRAC);
  localparam logic signed [W-1:0] V_HI_Q = W'(V_HI_V <<< FRAC);
  localparam logic signed [W-1:0] SLOPE_Q =
    W'(((P_MAX_W - P_MIN_W) <<< FRAC) / (V_HI_V - V_LO_V));
  localparam logic signed [W-1:0] P_MAX_Q = W'(V_HI_V * SLOPE_Q);
  localparam logic signed [W-1:0] P_MIN_Q = W'(V_LO_V * SLOPE_Q);
  localparam logic signed [W-1:0] MARGIN_MIN_Q = ONE_Q;
  localparam logic signed [W-1:0] MARGIN_MAX_Q = W'((14 * ONE_Q) / 10);
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int TS_NS  = 100_000;         // control interval, ns
  localparam logic [7:0] DIV_STEPS = 8'h30;
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_VPI, ST_VDIV, ST_IPI, ST_DDIV, ST_OUT
  } pfcdc_state_t;
endpackage
`default_nettype wire

// File: sim/pfcdc_plant.sv
/*
  Boost stage seen from the controller: one strobe per request, samples.
  Assumes the bench sets the sample values and raises go_i.
*/
`timescale 1ns/1ps
`default_nettype none
module pfcdc_plant
  import pfcdc_pkg::*;
(
  input  wire logic                core_clk_i, // control clock
  input  wire logic                rst_i,      // async reset
  input  wire logic                go_i,       // start one interval
  input  wire logic                busy_i,     // controller busy
  input  wire logic signed [W-1:0] vac_set_i,  // next ac sample
  input  wire logic signed [W-1:0] vrms_set_i, // next rms sample
  input  wire logic signed [W-1:0] ipfc_set_i, // next current sample
  input  wire logic signed [W-1:0] vdc_set_i,  // next bus sample
  output logic                     stb_o,      // sample strobe
  output logic signed [W-1:0]      vac_o,      // ac volts
  output logic signed [W-1:0]      vrms_o,     // rms volts
  output logic signed [W-1:0]      ipfc_o,     // reactor current
  output logic signed [W-1:0]      vdc_o       // bus volts
);
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stb_o <= 1'b0;
      vac_o <= '0;
      vrms_o <= '0;
      ipfc_o <= '0;
      vdc_o <= '0;
    end else if (go_i && !busy_i && !stb_o) begin
      stb_o <= 1'b1;
      vac_o <= vac_set_i;
      vrms_o <= vrms_set_i;
      ipfc_o <= ipfc_set_i;
      vdc_o <= vdc_set_i;
    end else begin
      stb_o <= 1'b0;
      if (stb_o) begin
        // samples go stale once taken, so a late read shows garbage
        vac_o <= ~vac_o;
        vrms_o <= ~vrms_o;
        ipfc_o <= ~ipfc_o;
        vdc_o <= ~vdc_o;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
/*
  Scenario bench for the pfc controller.
  Assumes the plant model supplies strobes and samples.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pfcdc_pkg::*;
  typedef logic signed [W-1:0] pfcdc_q_t;
  logic     core_clk_i = 1'b0;
  logic     rst_i = 1'b1;
  logic     go = 1'b0;
  pfcdc_q_t vac_s = '0, vrms_s = '0, ipfc_s = '0, vdc_s = '0;
  pfcdc_q_t vcmd = '0, kp_v = '0, ki_v = '0, kp_i = '0, ki_i = '0;
  pfcdc_q_t margin = 32'sh0000_1000, dlim = 32'sh0000_1000, ss = '0;
  pfcdc_q_t vac, vrms, ipfc, vdc, duty, iref, pdem;
  logic     stb, busy, done;
  int       n_mismatch = 0;
  int       n_checks = 0;

  initial forever #10 core_clk_i = ~core_clk_i;

  pfcdc_plant u_plant (.core_clk_i(core_clk_i), .rst_i(rst_i), .go_i(go), .busy_i(busy),
    .vac_set_i(vac_s), .vrms_set_i(vrms_s), .ipfc_set_i(ipfc_s), .vdc_set_i(vdc_s),
    .stb_o(stb), .vac_o(vac), .vrms_o(vrms), .ipfc_o(ipfc), .vdc_o(vdc));
  pfcdc_ctrl uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .sample_stb_i(stb), .vac_i(vac),
    .vrms_i(vrms), .ipfc_i(ipfc), .vdc_i(vdc), .vcmd_i(vcmd), .kp_v_i(kp_v), .ki_v_i(ki_v),
    .kp_i_i(kp_i), .ki_i_i(ki_i), .margin_i(margin), .duty_lim_i(dlim), .ss_step_i(ss),
    .duty_o(duty), .iref_o(iref), .pdem_o(pdem), .busy_o(busy), .done_o(done));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  function automatic pfcdc_q_t q(input int v);
    return W'(v) <<< FRAC;
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input pfcdc_q_t got, input pfcdc_q_t exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // divider results may differ in the last bits, so allow a small band
  task automatic near(input pfcdc_q_t got, input pfcdc_q_t exp, input pfcdc_q_t tol);
    pfcdc_q_t d;
    d = got - exp;
    n_checks++;
    if ((d <= tol && d >= -tol) !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic step(input pfcdc_q_t a, input pfcdc_q_t r, input pfcdc_q_t i,
                      input pfcdc_q_t d);
    int k;
    @(posedge core_clk_i);
    vac_s <= a;
    vrms_s <= r;
    ipfc_s <= i;
    vdc_s <= d;
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      k++;
      if (k == 1) chk({31'h0, busy}, 32'sh1);
    end while (done !== 1'b1 && k < 300);
    if (done !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, done, 1'b1);
      results();
    end
    // strobe edge, vpi, ipi and out steps, and two divides of DIV_STEPS + 1
    chk(k, 2 * (int'(DIV_STEPS) + 1) + 4);
    chk({31'h0, busy}, '0);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_limit();
    int vr[5] = '{50, 100, 150, 200, 250};
    int pw[5] = '{500, 500, 750, 1000, 1000};
    @(posedge core_clk_i);
    kp_v <= q(100);
    vcmd <= q(400);
    for (int k = 0; k < 5; k++) begin
      do_reset();
      step('0, q(vr[k]), '0, q(300));
      chk(pdem, q(pw[k]));
    end
    @(posedge core_clk_i);
    margin <= q(2);
    do_reset();
    step('0, q(250), '0, q(300));
    chk(pdem, 32'sh0057_7E70);
    @(posedge core_clk_i);
    margin <= 32'sh0000_0800;
    do_reset();
    step('0, q(250), '0, q(300));
    chk(pdem, q(1000));
    $display("test limit finished");
  endtask

  task automatic t_reset();
    do_reset();
    #1;
    chk(duty, '0);
    chk(pdem | iref, '0);
    chk({30'h0, busy, done}, '0);
    $display("test reset finished");
  endtask

  task automatic t_vloop();
    @(posedge core_clk_i);
    kp_v <= q(2);
    vcmd <= q(310);
    do_reset();
    step('0, q(150), '0, q(300));
    chk(pdem, q(20));
    @(posedge core_clk_i);
    vcmd <= q(290);
    step('0, q(150), '0, q(300));
    chk(pdem, '0);
    @(posedge core_clk_i);
    kp_v <= '0;
    ki_v <= q(1000);
    vcmd <= q(310);
    do_reset();
    step('0, q(150), '0, q(300));
    near(pdem, q(1), 32'sh20);
    $display("test voltage loop finished");
  endtask

  task automatic t_ff();
    @(posedge core_clk_i);
    kp_v <= q(100);
    ki_v <= '0;
    vcmd <= q(400);
    do_reset();
    step(q(100), q(200), '0, q(300));
    near(iref, 32'sh2800, 32'sh8);
    step(-q(100), q(200), '0, q(300));
    near(iref, -32'sh2800, 32'sh8);
    $display("test feedforward finished");
  endtask

  task automatic t_duty();
    @(posedge core_clk_i);
    vcmd <= '0;
    ss <= 32'sh0000_0400;
    do_reset();
    step(q(100), q(150), '0, q(400));
    chk({31'h0, duty < 32'sh0000_0C00}, 32'sh1);
    repeat (4) step(q(100), q(150), '0, q(400));
    near(duty, 32'sh0C00, 32'sh4);
    @(posedge core_clk_i);
    dlim <= 32'sh0000_0800;
    step(q(100), q(150), '0, q(400));
    chk(duty, 32'sh0800);
    $display("test duty finished");
  endtask

  task automatic t_cur();
    @(posedge core_clk_i);
    ss <= '0;
    kp_i <= q(1);
    do_reset();
    step('0, q(150), -32'sh400, q(400));
    chk(duty, 32'sh0400);
    step('0, q(150), 32'sh400, q(400));
    chk(duty, '0);
    @(posedge core_clk_i);
    ki_i <= 32'sh0000_0800;
    do_reset();
    step('0, q(150), -q(2), q(400));
    chk(duty, 32'sh0800);
    step('0, q(150), -32'sh400, q(400));
    chk(duty, '0);
    $display("test current loop finished");
  endtask

  initial begin
    do_reset();
    t_limit();
    t_reset();
    t_vloop();
    t_ff();
    t_duty();
    t_cur();
    results();
  end
endmodule
`default_nettype wire
